// ==== shared/fp_regs_pkg.sv ====
package fp_regs_pkg;

  // Memory-mapped addresses of the two context registers.
  localparam logic [31:0] CTX_CTRL_ADDR = 32'he000ef34;
  localparam logic [31:0] CTX_ADDR_ADDR = 32'he000ef38;

  // Reset values.
  localparam logic [31:0] CTX_CTRL_RESET = 32'hc0000000;
  localparam logic [31:0] CTX_ADDR_RESET = 32'h00000000;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;

  // Context control field positions.
  localparam int CC_AUTO_PRESERVE = 31;
  localparam int CC_LAZY_ENABLE = 30;
  localparam int CC_MON_OK = 8;
  localparam int CC_BUS_FAULT_OK = 6;
  localparam int CC_MEM_FAULT_OK = 5;
  localparam int CC_HARD_FAULT_OK = 4;
  localparam int CC_THREAD = 3;
  localparam int CC_USER = 1;
  localparam int CC_LAZY_ACTIVE = 0;

  // Context address field.
  localparam int CA_ADDR_LSB = 3;
  localparam int CA_ADDR_W = 29;

  // Status/control field positions.
  localparam int SC_NZCV_LSB = 28;
  localparam int SC_ALT_HALF = 26;
  localparam int SC_DEFAULT_NAN = 25;
  localparam int SC_FLUSH = 24;
  localparam int SC_ROUND_LSB = 22;
  localparam int SC_IDC = 7;
  localparam int SC_IXC = 4;
  localparam int SC_UFC = 3;
  localparam int SC_OFC = 2;
  localparam int SC_DZC = 1;
  localparam int SC_IOC = 0;

  // Packed exception flag vector order: {idc, ixc, ufc, ofc, dzc, ioc}.
  localparam int FLAG_N = 6;

  typedef enum logic [1:0] {
    ROUND_NEAREST,
    ROUND_PLUS_INF,
    ROUND_MINUS_INF,
    ROUND_ZERO
  } rounding_t;

  typedef enum {
    RESP_IDLE,
    RESP_READ
  } resp_state_t;

endpackage

// ==== src/fp_sticky_flags.sv ====
`timescale 1ns/1ps
module fp_sticky_flags (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [fp_regs_pkg::FLAG_N-1:0] i_raise,
  input wire logic i_wr,
  input wire logic [fp_regs_pkg::FLAG_N-1:0] i_wr_data,
  output logic [fp_regs_pkg::FLAG_N-1:0] o_flags
);
  import fp_regs_pkg::*;

  typedef struct packed {
    logic [FLAG_N-1:0] flags;
  } sticky_state_t;

  sticky_state_t state;
  sticky_state_t next_state;

  // A write stores the written value, but an exception raised in the same
  // cycle still lands, so a clearing write never hides a fresh event.
  always_comb begin
    next_state = state;
    if (i_wr) begin
      next_state.flags = i_wr_data; // [R17]
    end
    next_state.flags = next_state.flags | i_raise; // [R17]
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_flags = state.flags;

endmodule // fp_sticky_flags

// ==== src/fpu_context_status_regs.sv ====
`timescale 1ns/1ps
// Functional notes
// R01: With auto-preserve enabled, an FP instruction sets the context-active flag.
// R02: Lazy-preserve enable selects lazy state preservation; zero disables it.
// R03: Frame allocation records in bit 8 if the debug monitor could pend.
// R04: Frame allocation records in bit 6 if bus fault could pend.
// R05: Frame allocation records in bit 5 if memory fault could pend.
// R06: Frame allocation records in bit 4 if hard fault could pend.
// R07: Frame allocation records in bit 3 whether the core was in thread mode.
// R08: Frame allocation records in bit 1 whether execution was unprivileged.
// R09: Bit 0 reads one while a reserved frame awaits its deferred save.
// R10: Context address bits 31:3 hold the reserved frame space address.
// R11: Context address bits 2:0 read zero and ignore writes.
// R12: FP compares update the N, Z, C, V flags in bits 31:28.
// R13: Status bit 26 picks IEEE or alternative half-precision format.
// R14: Status bit 25 set makes NaN inputs return the default NaN.
// R15: Status bit 24 set enables flush-to-zero; clear means full IEEE.
// R16: Bits 23:22 pick nearest, plus infinity, minus infinity or zero rounding.
// R17: Each cumulative flag sets on its exception and holds until written zero.
// R18: Flags sit at 7 denormal, 4 inexact, 3 under, 2 over, 1 div0, 0 invalid.
// R19: Status register is reached only by move instructions with the FPU enabled.
// R20: Lazy-active clears once the deferred state is written to the frame.
module fpu_context_status_regs (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  // Memory-mapped access to the two context registers.
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [31:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_priv,
  output logic o_reg_rvalid,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_err,
  // Move-to and move-from instructions for the status/control register.
  input wire logic i_fpu_enabled,
  input wire logic i_status_rd,
  input wire logic i_status_wr,
  input wire logic [31:0] i_status_wdata,
  output logic o_status_rvalid,
  output logic [31:0] o_status_rdata,
  output logic o_status_err,
  // Pipeline events.
  input wire logic i_fp_instr_exec,
  input wire logic i_cmp_valid,
  input wire logic [3:0] i_cmp_nzcv,
  input wire logic [fp_regs_pkg::FLAG_N-1:0] i_exc_raise,
  // Exception entry: stack frame allocation and later deferred save.
  input wire logic i_frame_alloc,
  input wire logic [31:0] i_frame_addr,
  input wire logic i_debug_monitor_pend_ok,
  input wire logic i_bus_fault_pend_ok,
  input wire logic i_mem_fault_pend_ok,
  input wire logic i_hard_fault_pend_ok,
  input wire logic i_thread_mode,
  input wire logic i_user_level,
  input wire logic i_lazy_save_done,
  // Controls towards the datapath and the core.
  output logic o_fp_context_active_flag,
  output logic o_auto_preserve_enable,
  output logic o_lazy_preserve_enable,
  output logic o_lazy_preserve_active,
  output logic o_alt_half_format,
  output logic o_default_nan_mode,
  output logic o_flush_denormals,
  output logic [1:0] o_rounding_select,
  output logic [3:0] o_nzcv
);
  import fp_regs_pkg::*;

  typedef struct packed {
    logic auto_preserve_enable;
    logic lazy_preserve_enable;
    logic debug_monitor_pend_ok;
    logic bus_fault_pend_ok;
    logic mem_fault_pend_ok;
    logic hard_fault_pend_ok;
    logic thread_mode;
    logic user_level;
    logic lazy_preserve_active;
    logic [CA_ADDR_W-1:0] context_addr;
    logic [3:0] nzcv;
    logic alt_half_format;
    logic default_nan_mode;
    logic flush_denormals;
    logic [1:0] rounding_select;
    logic fp_context_active_flag;
    resp_state_t reg_resp;
    logic [31:0] reg_rdata;
    logic reg_err;
    logic status_rvalid;
    logic [31:0] status_rdata;
    logic status_err;
  } regs_state_t;

  regs_state_t state;
  regs_state_t next_state;

  logic [FLAG_N-1:0] flags;
  logic flags_wr;
  logic [FLAG_N-1:0] flags_wdata;
  logic ctrl_hit;
  logic addr_hit;
  logic reg_ok;
  logic status_ok;
  logic [31:0] ctrl_view;
  logic [31:0] addr_view;
  logic [31:0] status_view;

  // Packs the cumulative flag vector into its bit places of the status word.
  function automatic logic [31:0] place_flags(input logic [FLAG_N-1:0] f);
    logic [31:0] w;
    w = '0;
    w[SC_IDC] = f[5];
    w[SC_IXC] = f[4];
    w[SC_UFC] = f[3];
    w[SC_OFC] = f[2];
    w[SC_DZC] = f[1];
    w[SC_IOC] = f[0];
    return w;
  endfunction

  // Inverse of place_flags; also used for writes.
  function automatic logic [FLAG_N-1:0] pick_flags(input logic [31:0] w);
    return {w[SC_IDC], w[SC_IXC], w[SC_UFC], w[SC_OFC], w[SC_DZC], w[SC_IOC]};
  endfunction

  assign ctrl_hit = i_reg_addr == CTX_CTRL_ADDR;
  assign addr_hit = i_reg_addr == CTX_ADDR_ADDR;

  // Both context registers are privileged; an unprivileged access is
  // refused with an error instead of silently succeeding.
  assign reg_ok = i_reg_priv && (ctrl_hit || addr_hit);

  // No memory-mapped path reaches the status register at all.
  assign status_ok = i_fpu_enabled; // [R19]

  always_comb begin
    ctrl_view = '0;
    ctrl_view[CC_AUTO_PRESERVE] = state.auto_preserve_enable;
    ctrl_view[CC_LAZY_ENABLE] = state.lazy_preserve_enable;
    ctrl_view[CC_MON_OK] = state.debug_monitor_pend_ok;
    ctrl_view[CC_BUS_FAULT_OK] = state.bus_fault_pend_ok;
    ctrl_view[CC_MEM_FAULT_OK] = state.mem_fault_pend_ok;
    ctrl_view[CC_HARD_FAULT_OK] = state.hard_fault_pend_ok;
    ctrl_view[CC_THREAD] = state.thread_mode;
    ctrl_view[CC_USER] = state.user_level;
    ctrl_view[CC_LAZY_ACTIVE] = state.lazy_preserve_active; // [R09]
  end

  always_comb begin
    addr_view = '0;
    addr_view[31:CA_ADDR_LSB] = state.context_addr; // [R10]
  end

  always_comb begin
    status_view = place_flags(flags); // [R18]
    status_view[31:SC_NZCV_LSB] = state.nzcv;
    status_view[SC_ALT_HALF] = state.alt_half_format;
    status_view[SC_DEFAULT_NAN] = state.default_nan_mode;
    status_view[SC_FLUSH] = state.flush_denormals;
    status_view[SC_ROUND_LSB+1:SC_ROUND_LSB] = state.rounding_select;
  end

  assign flags_wr = i_status_wr && status_ok; // [R19]
  assign flags_wdata = pick_flags(i_status_wdata); // [R18]

  always_comb begin
    next_state = state;

    // Software writes to the context control register.
    if (i_reg_wr && reg_ok && ctrl_hit) begin
      next_state.auto_preserve_enable = i_reg_wdata[CC_AUTO_PRESERVE];
      next_state.lazy_preserve_enable = i_reg_wdata[CC_LAZY_ENABLE];
      next_state.debug_monitor_pend_ok = i_reg_wdata[CC_MON_OK];
      next_state.bus_fault_pend_ok = i_reg_wdata[CC_BUS_FAULT_OK];
      next_state.mem_fault_pend_ok = i_reg_wdata[CC_MEM_FAULT_OK];
      next_state.hard_fault_pend_ok = i_reg_wdata[CC_HARD_FAULT_OK];
      next_state.thread_mode = i_reg_wdata[CC_THREAD];
      next_state.user_level = i_reg_wdata[CC_USER];
      next_state.lazy_preserve_active = i_reg_wdata[CC_LAZY_ACTIVE];
    end

    // Low three address bits are not stored, so they stay zero.
    if (i_reg_wr && reg_ok && addr_hit) begin
      next_state.context_addr = i_reg_wdata[31:CA_ADDR_LSB]; // [R11]
    end

    // Deferred save done: the reserved frame space is now filled.
    if (i_lazy_save_done) begin
      next_state.lazy_preserve_active = 1'b0; // [R20]
    end

    // Frame allocation takes priority over a software write or a save
    // completion in the same cycle, so a new reservation is never lost.
    if (i_frame_alloc) begin
      next_state.debug_monitor_pend_ok = i_debug_monitor_pend_ok; // [R03]
      next_state.bus_fault_pend_ok = i_bus_fault_pend_ok; // [R04]
      next_state.mem_fault_pend_ok = i_mem_fault_pend_ok; // [R05]
      next_state.hard_fault_pend_ok = i_hard_fault_pend_ok; // [R06]
      next_state.thread_mode = i_thread_mode; // [R07]
      next_state.user_level = i_user_level; // [R08]
      next_state.context_addr = i_frame_addr[31:CA_ADDR_LSB]; // [R10]
      next_state.lazy_preserve_active = state.lazy_preserve_enable; // [R02] [R09]
    end

    // The core clears its own context-active flag on exception return;
    // this block only produces the set request.
    next_state.fp_context_active_flag = i_fp_instr_exec && state.auto_preserve_enable; // [R01]

    // Move-to from software.
    if (flags_wr) begin
      next_state.nzcv = i_status_wdata[31:SC_NZCV_LSB];
      next_state.alt_half_format = i_status_wdata[SC_ALT_HALF]; // [R13]
      next_state.default_nan_mode = i_status_wdata[SC_DEFAULT_NAN]; // [R14]
      next_state.flush_denormals = i_status_wdata[SC_FLUSH]; // [R15]
      next_state.rounding_select = i_status_wdata[SC_ROUND_LSB+1:SC_ROUND_LSB]; // [R16]
    end

    // A compare retiring with a write lands last, keeping its result.
    if (i_cmp_valid) begin
      next_state.nzcv = i_cmp_nzcv; // [R12]
    end

    // Context register read response, one cycle after the request.
    next_state.reg_resp = RESP_IDLE;
    next_state.reg_err = 1'b0;
    next_state.reg_rdata = '0;
    if (i_reg_rd || i_reg_wr) begin
      next_state.reg_err = !reg_ok;
    end
    if (i_reg_rd) begin
      next_state.reg_resp = RESP_READ;
      if (reg_ok) begin
        next_state.reg_rdata = ctrl_hit ? ctrl_view : addr_view;
      end
    end

    // Status register move-from; refused while the FPU is disabled.
    next_state.status_rvalid = i_status_rd && status_ok; // [R19]
    next_state.status_err = (i_status_rd || i_status_wr) && !status_ok; // [R19]
    next_state.status_rdata = '0;
    if (i_status_rd && status_ok) begin
      next_state.status_rdata = status_view;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= '0;
      state.auto_preserve_enable <= CTX_CTRL_RESET[CC_AUTO_PRESERVE];
      state.lazy_preserve_enable <= CTX_CTRL_RESET[CC_LAZY_ENABLE];
      state.context_addr <= CTX_ADDR_RESET[31:CA_ADDR_LSB];
      state.nzcv <= STATUS_RESET[31:SC_NZCV_LSB];
      state.rounding_select <= STATUS_RESET[SC_ROUND_LSB+1:SC_ROUND_LSB];
      state.reg_resp <= RESP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Cumulative exception flags live in their own sticky block.
  fp_sticky_flags u_flags (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_raise(i_exc_raise), // [R17]
    .i_wr(flags_wr),
    .i_wr_data(flags_wdata),
    .o_flags(flags)
  );

  always_comb begin
    case (state.reg_resp)
      RESP_READ: o_reg_rvalid = 1'b1;
      default: o_reg_rvalid = 1'b0;
    endcase
  end

  assign o_reg_rdata = state.reg_rdata;
  assign o_reg_err = state.reg_err;
  assign o_status_rvalid = state.status_rvalid;
  assign o_status_rdata = state.status_rdata;
  assign o_status_err = state.status_err;

  assign o_fp_context_active_flag = state.fp_context_active_flag; // [R01]
  assign o_auto_preserve_enable = state.auto_preserve_enable;
  assign o_lazy_preserve_enable = state.lazy_preserve_enable; // [R02]
  assign o_lazy_preserve_active = state.lazy_preserve_active; // [R09]
  assign o_alt_half_format = state.alt_half_format; // [R13]
  assign o_default_nan_mode = state.default_nan_mode; // [R14]
  assign o_flush_denormals = state.flush_denormals; // [R15]
  assign o_rounding_select = state.rounding_select; // [R16]
  assign o_nzcv = state.nzcv; // [R12]

endmodule // fpu_context_status_regs

// ==== bench/fpu_context_status_regs_checker.sv ====
`timescale 1ns/1ps
module fpu_context_status_regs_checker (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_reg_wr,
  input wire logic i_fpu_enabled,
  input wire logic i_status_wr,
  input wire logic [31:0] i_status_wdata,
  input wire logic o_status_err,
  input wire logic i_fp_instr_exec,
  input wire logic i_cmp_valid,
  input wire logic [3:0] i_cmp_nzcv,
  input wire logic i_frame_alloc,
  input wire logic i_lazy_save_done,
  input wire logic o_fp_context_active_flag,
  input wire logic o_auto_preserve_enable,
  input wire logic o_lazy_preserve_enable,
  input wire logic o_lazy_preserve_active,
  input wire logic o_alt_half_format,
  input wire logic o_default_nan_mode,
  input wire logic o_flush_denormals,
  input wire logic [1:0] o_rounding_select,
  input wire logic [3:0] o_nzcv
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  a_flag_set: assert property (
    i_fp_instr_exec && o_auto_preserve_enable |=> o_fp_context_active_flag) else $error("flag");
  a_flag_quiet: assert property (
    i_fp_instr_exec && !o_auto_preserve_enable |=> !o_fp_context_active_flag) else $error("f");
  a_flag_cause: assert property (
    o_fp_context_active_flag |-> $past(i_fp_instr_exec)) else $error("flag cause");
  a_lazy_set: assert property (
    i_frame_alloc && o_lazy_preserve_enable |=> o_lazy_preserve_active) else $error("lazy");
  a_lazy_clear: assert property (
    i_lazy_save_done && !i_frame_alloc && !i_reg_wr |=> !o_lazy_preserve_active)
    else $error("lazy clear");
  a_nzcv_cmp: assert property (
    i_cmp_valid |=> o_nzcv == $past(i_cmp_nzcv)) else $error("nzcv");
  a_status_wr: assert property (
    i_status_wr && i_fpu_enabled |=> {o_alt_half_format, o_default_nan_mode,
    o_flush_denormals, o_rounding_select} == $past(i_status_wdata[26:22])) else $error("st");
  a_status_gate: assert property (
    i_status_wr && !i_fpu_enabled |=> o_status_err && $stable(o_rounding_select))
    else $error("gate");
endmodule // fpu_context_status_regs_checker
bind fpu_context_status_regs fpu_context_status_regs_checker chk (
  .i_sys_clk, .i_rstn, .i_reg_wr, .i_fpu_enabled, .i_status_wr, .i_status_wdata,
  .o_status_err, .i_fp_instr_exec, .i_cmp_valid, .i_cmp_nzcv, .i_frame_alloc,
  .i_lazy_save_done, .o_fp_context_active_flag, .o_auto_preserve_enable,
  .o_lazy_preserve_enable, .o_lazy_preserve_active, .o_alt_half_format,
  .o_default_nan_mode, .o_flush_denormals, .o_rounding_select, .o_nzcv
);

// ==== bench/core_model.sv ====
`timescale 1ns/1ps
module core_model (
  input wire logic i_sys_clk,
  output logic o_fp_instr_exec = 1'b0,
  output logic o_cmp_valid = 1'b0,
  output logic [3:0] o_cmp_nzcv = 4'h0,
  output logic [5:0] o_exc_raise = 6'h0,
  output logic o_frame_alloc = 1'b0,
  output logic [31:0] o_frame_addr = 32'h0,
  output logic [5:0] o_frame_state = 6'h0,
  output logic o_lazy_save_done = 1'b0
);
  // Qualifiers are inverted once their pulse ends, so a late capture reads wrong data.
  task automatic alloc(input logic [31:0] a, input logic [5:0] s);
    @(negedge i_sys_clk);
    o_frame_alloc = 1'b1;
    o_frame_addr = a;
    o_frame_state = s;
    @(negedge i_sys_clk);
    o_frame_alloc = 1'b0;
    o_frame_addr = ~a;
    o_frame_state = ~s;
  endtask
  task automatic pulse(input logic [1:0] k, input logic [5:0] v);
    @(negedge i_sys_clk);
    o_fp_instr_exec = (k == 2'd0);
    o_cmp_valid = (k == 2'd1);
    o_cmp_nzcv = v[3:0];
    o_exc_raise = (k == 2'd2) ? v : 6'h0;
    o_lazy_save_done = (k == 2'd3);
    @(negedge i_sys_clk);
    {o_fp_instr_exec, o_cmp_valid, o_exc_raise, o_lazy_save_done} = '0;
    o_cmp_nzcv = ~v[3:0];
  endtask
endmodule // core_model

// ==== bench/test_fpu_context_status_regs.sv ====
`timescale 1ns/1ps
module test_fpu_context_status_regs;
  import fp_regs_pkg::*;
  logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_reg_priv = 1'b1, i_fpu_enabled = 1'b1;
  logic i_reg_rd = 1'b0, i_reg_wr = 1'b0, i_status_rd = 1'b0, i_status_wr = 1'b0;
  logic [31:0] i_reg_addr = '0, i_reg_wdata = '0, i_status_wdata = '0;
  logic i_fp_instr_exec, i_cmp_valid, i_frame_alloc, i_lazy_save_done, er, rv;
  logic [3:0] i_cmp_nzcv, o_nzcv;
  logic [5:0] i_exc_raise, st;
  logic [31:0] i_frame_addr, o_reg_rdata, o_status_rdata, rd;
  logic o_reg_rvalid, o_reg_err, o_status_rvalid, o_status_err, o_fp_context_active_flag;
  logic o_auto_preserve_enable, o_lazy_preserve_enable, o_lazy_preserve_active;
  logic o_alt_half_format, o_default_nan_mode, o_flush_denormals;
  logic [1:0] o_rounding_select;
  int fail_count = 0, checks_done = 0, cycles = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  fpu_context_status_regs dut (
    .i_sys_clk, .i_rstn, .i_reg_rd, .i_reg_wr, .i_reg_addr, .i_reg_wdata, .i_reg_priv,
    .o_reg_rvalid, .o_reg_rdata, .o_reg_err, .i_fpu_enabled, .i_status_rd, .i_status_wr,
    .i_status_wdata, .o_status_rvalid, .o_status_rdata, .o_status_err, .i_fp_instr_exec,
    .i_cmp_valid, .i_cmp_nzcv, .i_exc_raise, .i_frame_alloc, .i_frame_addr,
    .i_debug_monitor_pend_ok(st[5]), .i_bus_fault_pend_ok(st[4]), .i_mem_fault_pend_ok(st[3]),
    .i_hard_fault_pend_ok(st[2]), .i_thread_mode(st[1]), .i_user_level(st[0]),
    .i_lazy_save_done, .o_fp_context_active_flag, .o_auto_preserve_enable,
    .o_lazy_preserve_enable, .o_lazy_preserve_active, .o_alt_half_format,
    .o_default_nan_mode, .o_flush_denormals, .o_rounding_select, .o_nzcv
  );
  core_model core (
    .i_sys_clk, .o_fp_instr_exec(i_fp_instr_exec), .o_cmp_valid(i_cmp_valid),
    .o_cmp_nzcv(i_cmp_nzcv), .o_exc_raise(i_exc_raise), .o_frame_alloc(i_frame_alloc),
    .o_frame_addr(i_frame_addr), .o_frame_state(st), .o_lazy_save_done(i_lazy_save_done)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(negedge i_sys_clk);
    {i_reg_rd, i_reg_wr, i_reg_addr, i_reg_wdata} = {~w, w, a, d};
    @(negedge i_sys_clk);
    {rd, er, rv} = {o_reg_rdata, o_reg_err, o_reg_rvalid};
    {i_reg_rd, i_reg_wr} = 2'b00;
  endtask
  task automatic sbus(input logic w, input logic [31:0] d);
    @(negedge i_sys_clk);
    {i_status_rd, i_status_wr, i_status_wdata} = {~w, w, d};
    @(negedge i_sys_clk);
    {rd, er, rv} = {o_status_rdata, o_status_err, o_status_rvalid};
    {i_status_rd, i_status_wr} = 2'b00;
  endtask
  task automatic t_auto;
    bus(1'b0, CTX_CTRL_ADDR, '0);
    check(rd, 32'hc0000000);
    check(rv, 1'b1);
    core.pulse(2'd0, '0);
    check(o_fp_context_active_flag, 1'b1);
    bus(1'b1, CTX_CTRL_ADDR, 32'h40000000);
    core.pulse(2'd0, '0);
    check(o_fp_context_active_flag, 1'b0);
    bus(1'b1, CTX_CTRL_ADDR, 32'h80000000);
    check(o_auto_preserve_enable, 1'b1);
    check(o_lazy_preserve_enable, 1'b0);
    core.alloc(32'h20001007, '0);
    bus(1'b0, CTX_CTRL_ADDR, '0);
    check(rd, 32'h80000000);
    bus(1'b1, CTX_CTRL_ADDR, 32'hc0000000);
  endtask
  task automatic t_alloc;
    int pos[6] = '{1, 3, 4, 5, 6, 8};
    for (int i = 0; i < 6; i++) begin
      core.alloc(32'h20001007 + (i << 4), 6'h1 << i);
      bus(1'b0, CTX_CTRL_ADDR, '0);
      check(rd, 32'hc0000001 | (32'h1 << pos[i]));
      check(o_lazy_preserve_active, 1'b1);
      bus(1'b0, CTX_ADDR_ADDR, '0);
      check(rd, 32'h20001000 + (i << 4));
    end
    core.pulse(2'd3, '0);
    check(o_lazy_preserve_active, 1'b0);
    bus(1'b0, CTX_CTRL_ADDR, '0);
    check(rd, 32'hc0000100);
    bus(1'b1, CTX_ADDR_ADDR, 32'hffffffff);
    bus(1'b0, CTX_ADDR_ADDR, '0);
    check(rd, 32'hfffffff8);
    bus(1'b0, CTX_ADDR_ADDR + 32'h4, '0);
    check(rd, 32'h0);
    check(er, 1'b1);
    // An unprivileged write must be refused and leave the address untouched.
    i_reg_priv = 1'b0;
    bus(1'b1, CTX_ADDR_ADDR, 32'h0);
    check(er, 1'b1);
    i_reg_priv = 1'b1;
    bus(1'b0, CTX_ADDR_ADDR, '0);
    check(rd, 32'hfffffff8);
  endtask
  task automatic t_status;
    logic [31:0] d;
    for (int r = 0; r < 4; r++) begin
      d = (32'(r) << 22) | (r[0] ? 32'h05000000 : 32'h02000000);
      sbus(1'b1, d);
      check({o_alt_half_format, o_default_nan_mode, o_flush_denormals, o_rounding_select},
        d[26:22]);
    end
    sbus(1'b1, 32'hffffffff);
    sbus(1'b0, '0);
    check(rd, 32'hf7c0009f);
    check(rv, 1'b1);
    i_fpu_enabled = 1'b0;
    sbus(1'b1, '0);
    check(er, 1'b1);
    check(rv, 1'b0);
    i_fpu_enabled = 1'b1;
    sbus(1'b0, '0);
    check(rd, 32'hf7c0009f);
    sbus(1'b1, '0);
    core.pulse(2'd1, 6'h0a);
    check(o_nzcv, 4'ha);
    for (int i = 0; i < 6; i++) begin
      core.pulse(2'd2, 6'h1 << i);
      sbus(1'b0, '0);
      check(rd, 32'ha0000000 | (i == 5 ? 32'h9f : (32'h2 << i) - 1));
    end
  endtask
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_rstn = 1'b1;
    t_auto();
    t_alloc();
    t_status();
    finish_test();
  end
endmodule // test_fpu_context_status_regs
